// ---- rtl/fss_regs.svh ----
// Constants for the frequency sweep sequencer
`ifndef FSS_REGS_SVH
`define FSS_REGS_SVH
`define FSS_SEGS        100
`define FSS_LAST_SEG    7'h63
`define FSS_ERR_EMPTY   10'h25D
`define FSS_ERR_LIMIT   10'h001
`define FSS_LOG_SINGLE  5'h0A
`define FSS_LOG_CONT    5'h02
`define FSS_FREQ_RST    32'h000F4240
`define FSS_STOP_RST    32'h00989680
`define FSS_MKR_RST     32'h004C4B40
`define FSS_TIME_RST    32'h00000064
`define FSS_CLK_HZ      10000000
`define FSS_TICK_HZ     1000
`define FSS_TICK_CYC    (`FSS_CLK_HZ / `FSS_TICK_HZ)
`endif

// ---- rtl/fss_pkg.sv ----
// Types for the frequency sweep sequencer
package fss_pkg;
  typedef enum logic [1:0] {FSS_LIN, FSS_LOG, FSS_DISC} fss_mode_e;
  typedef enum logic [2:0] {FSS_IDLE, FSS_ARMED, FSS_RUN, FSS_HELD, FSS_SEEK} fss_state_e;
endpackage

// ---- rtl/fss_sweep_seq.sv ----
// Frequency sweep sequencer: linear, log and discrete sweeps
`timescale 1ns/1ps
`include "fss_regs.svh"
module fss_sweep_seq #(
  parameter int FW       = 32,
  parameter int TW       = 32,
  parameter int TICK_CYC = `FSS_TICK_CYC
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // Mode and parameters
  input  wire logic [1:0]    mode_sel,
  input  wire logic          enh_on,
  input  wire logic [FW-1:0] start_in,
  input  wire logic [FW-1:0] stop_in,
  input  wire logic [FW-1:0] mkr_in,
  input  wire logic [TW-1:0] time_in,
  input  wire logic          par_load,
  input  wire logic [FW-1:0] f_min,
  input  wire logic [FW-1:0] f_max,
  // Command strobes
  input  wire logic          cmd_rst_start,
  input  wire logic          cmd_start,
  input  wire logic          cmd_bw_dbl,
  input  wire logic          cmd_bw_half,
  input  wire logic          cmd_abort,
  input  wire logic          cmd_other_par,
  input  wire logic          cmd_store,
  input  wire logic          cmd_recall,
  input  wire logic          cmd_clear,
  input  wire logic [6:0]    seg_idx,
  // Status
  output logic [FW-1:0]      freq_out,
  output logic [FW-1:0]      start_r,
  output logic [FW-1:0]      stop_r,
  output logic [FW-1:0]      mkr_r,
  output logic [TW-1:0]      time_r,
  output logic               single_act,
  output logic               cont_act,
  output logic               marker_out,
  output logic               xramp_rst,
  output logic               err_r,
  output logic [9:0]         err_code
);

  // Segment table with valid bits; stands in for the nonvolatile store
  logic [FW-1:0] t_start [`FSS_SEGS];
  logic [FW-1:0] t_stop  [`FSS_SEGS];
  logic [FW-1:0] t_mkr   [`FSS_SEGS];
  logic [TW-1:0] t_time  [`FSS_SEGS];
  logic [`FSS_SEGS-1:0] valid_r;

  fss_pkg::fss_state_e st_r;
  logic [FW-1:0] a_r, b_r, step_r, seg_end_r;
  logic [TW-1:0] tleft_r;
  logic [31:0]   tick_r;
  logic          up_r, cont_r;
  logic [6:0]    seg_r;
  logic [4:0]    piece_r;
  logic [FW:0]   span2;
  logic          tick;

  // Remaining pieces per log sweep share one step calculation
  function automatic logic [FW-1:0] fss_step(input logic [FW-1:0] lo, input logic [FW-1:0] hi,
                                             input logic [TW-1:0] t);
    logic [FW-1:0] d;
    d = (hi > lo) ? hi - lo : lo - hi;
    fss_step = (t == '0) ? d : d / FW'(t) + ((d % FW'(t)) != '0 ? FW'(1) : FW'(0));
  endfunction

  // Find next stored segment at or after an index
  function automatic logic [7:0] fss_next(input logic [6:0] from, input logic [`FSS_SEGS-1:0] v);
    fss_next = 8'hFF;
    for (int i = `FSS_SEGS - 1; i >= 0; i--)
      if (v[i] && 7'(i) >= from)
        fss_next = {1'b0, 7'(i)};
  endfunction

  wire logic is_disc = (mode_sel == 2'(fss_pkg::FSS_DISC));
  wire logic is_log  = (mode_sel == 2'(fss_pkg::FSS_LOG));
  wire logic stop_cmd = cmd_abort | (cmd_other_par & ~enh_on);
  wire logic [7:0] nxt0 = fss_next(7'h00, valid_r);
  wire logic [7:0] nxtn = fss_next(7'(seg_r + 7'h01), valid_r);

  // Sweep-time base: millisecond tick
  always_ff @(posedge clk)
    if (!rst_b || st_r != fss_pkg::FSS_RUN)
      tick_r <= '0;
    else if (tick)
      tick_r <= '0;
    else
      tick_r <= tick_r + 32'h00000001;
  assign tick = (tick_r == 32'(TICK_CYC - 1));

  // Table store and clear
  always_ff @(posedge clk)
    if (!rst_b)
      valid_r <= '0;
    else if (cmd_clear)
      valid_r <= '0;
    else if (cmd_store && seg_idx <= `FSS_LAST_SEG)
      valid_r[seg_idx] <= 1'b1;

  always_ff @(posedge clk)
    if (cmd_store && seg_idx <= `FSS_LAST_SEG)
    begin
      t_start[seg_idx] <= start_r;
      t_stop[seg_idx]  <= stop_r;
      t_mkr[seg_idx]   <= mkr_r;
      t_time[seg_idx]  <= time_r;
    end

  // Span scaling around the center; doubling flags an error if outside limits
  always_comb
  begin
    span2 = (stop_r > start_r) ? {1'b0, stop_r - start_r} : {1'b0, start_r - stop_r};
  end

  // Parameters, scaling, recall and error
  always_ff @(posedge clk)
    if (!rst_b)
    begin
      start_r  <= `FSS_FREQ_RST;
      stop_r   <= `FSS_STOP_RST;
      mkr_r    <= `FSS_MKR_RST;
      time_r   <= `FSS_TIME_RST;
      err_r    <= 1'b0;
      err_code <= '0;
    end
    else if (par_load)
    begin
      start_r <= start_in;
      stop_r  <= stop_in;
      mkr_r   <= mkr_in;
      time_r  <= time_in;
      err_r   <= 1'b0;
    end
    else if ((cmd_bw_dbl || cmd_bw_half) && !is_disc && !is_log)
    begin : scale
      logic [FW+1:0] c, h, lo, hi;
      c  = ({2'b0, start_r} + {2'b0, stop_r}) >> 1;
      h  = cmd_bw_dbl ? {1'b0, span2} : {2'b0, span2[FW:1]} >> 1;
      lo = c - h;
      hi = c + h;
      if (cmd_bw_dbl && (h > c || lo < {2'b0, f_min} || hi > {2'b0, f_max}))
      begin
        err_r    <= 1'b1;
        err_code <= `FSS_ERR_LIMIT;
      end
      else if (start_r <= stop_r)
      begin
        start_r <= lo[FW-1:0];
        stop_r  <= hi[FW-1:0];
      end
      else
      begin
        start_r <= hi[FW-1:0];
        stop_r  <= lo[FW-1:0];
      end
    end
    else if (cmd_recall)
    begin
      if (seg_idx > `FSS_LAST_SEG || !valid_r[seg_idx])
      begin
        err_r    <= 1'b1;
        err_code <= `FSS_ERR_EMPTY;
      end
      else
      begin
        start_r <= t_start[seg_idx];
        stop_r  <= t_stop[seg_idx];
        mkr_r   <= t_mkr[seg_idx];
        time_r  <= t_time[seg_idx];
      end
    end

  // Sweep state machine
  always_ff @(posedge clk)
    if (!rst_b)
    begin
      st_r       <= fss_pkg::FSS_IDLE;
      freq_out   <= `FSS_FREQ_RST;
      a_r        <= '0;
      b_r        <= '0;
      step_r     <= '0;
      seg_end_r  <= '0;
      tleft_r    <= '0;
      up_r       <= 1'b1;
      cont_r     <= 1'b0;
      seg_r      <= '0;
      piece_r    <= '0;
      single_act <= 1'b0;
      cont_act   <= 1'b0;
      marker_out <= 1'b0;
      xramp_rst  <= 1'b0;
    end
    else
    begin
      xramp_rst <= 1'b0;
      case (st_r)
        fss_pkg::FSS_IDLE, fss_pkg::FSS_HELD, fss_pkg::FSS_ARMED:
        begin
          marker_out <= 1'b0;
          if (cmd_start)
          begin
            cont_r   <= 1'b1;
            cont_act <= 1'b1;
            up_r     <= 1'b1;
            seg_r    <= 7'h7F; // Before entry 00
            st_r     <= is_disc ? fss_pkg::FSS_SEEK : fss_pkg::FSS_RUN;
            a_r      <= start_r;
            b_r      <= stop_r;
            freq_out <= start_r;
            tleft_r  <= time_r;
            piece_r  <= is_log ? `FSS_LOG_CONT : 5'h01;
            step_r   <= fss_step(start_r, is_log ? start_r + ((stop_r - start_r) >> 1)
                                 : stop_r, time_r);
            seg_end_r <= is_log ? start_r + ((stop_r - start_r) >> 1) : stop_r;
          end
          else if (cmd_rst_start && st_r != fss_pkg::FSS_ARMED)
          begin
            st_r      <= fss_pkg::FSS_ARMED;
            xramp_rst <= 1'b1;
            freq_out  <= (is_disc && !nxt0[7]) ? t_start[nxt0[6:0]] : start_r;
          end
          else if (cmd_rst_start)
          begin
            cont_r     <= 1'b0;
            single_act <= 1'b1;
            up_r       <= 1'b1;
            seg_r      <= 7'h7F; // Before entry 00
            st_r       <= is_disc ? fss_pkg::FSS_SEEK : fss_pkg::FSS_RUN;
            a_r        <= start_r;
            b_r        <= stop_r;
            tleft_r    <= time_r;
            piece_r    <= is_log ? `FSS_LOG_SINGLE : 5'h01;
            seg_end_r  <= is_log ? start_r + ((stop_r - start_r) / FW'(`FSS_LOG_SINGLE)) : stop_r;
            step_r     <= fss_step(start_r, is_log ? start_r + ((stop_r - start_r)
                                   / FW'(`FSS_LOG_SINGLE)) : stop_r, time_r);
          end
        end
        fss_pkg::FSS_SEEK:
        begin
          // Stop before loading, so a stopped sweep keeps its frequency
          if (cmd_rst_start || stop_cmd || cmd_start)
          begin
            st_r       <= fss_pkg::FSS_HELD;
            single_act <= 1'b0;
            cont_act   <= 1'b0;
          end
          // Past the last stored entry: wrap when continuous, else finish
          else if (nxtn[7])
          begin
            if (cont_r && !nxt0[7])
              seg_r <= 7'h7F;
            else
            begin
              st_r       <= fss_pkg::FSS_HELD;
              single_act <= 1'b0;
              cont_act   <= 1'b0;
            end
          end
          // 7'h7F stands before entry 00, so the search starts again at entry 00 and replays the first stored entry
          else
          begin : ld
            logic [6:0] s;
            s = nxtn[6:0];
            seg_r     <= s;
            a_r       <= t_start[s];
            b_r       <= t_stop[s];
            seg_end_r <= t_stop[s];
            freq_out  <= t_start[s];
            tleft_r   <= t_time[s];
            step_r    <= fss_step(t_start[s], t_stop[s], t_time[s]);
            up_r      <= 1'b1;
            st_r      <= fss_pkg::FSS_RUN;
          end
        end
        fss_pkg::FSS_RUN:
        begin
          // Marker on up-sweeps only; discrete marks both ways
          marker_out <= (up_r || is_disc) && ((b_r >= a_r) ? freq_out >= mkr_r
                        : freq_out <= mkr_r);
          if (cmd_start || cmd_rst_start || stop_cmd)
          begin
            st_r       <= fss_pkg::FSS_HELD;
            single_act <= 1'b0;
            cont_act   <= 1'b0;
            marker_out <= 1'b0;
          end
          else if (tick)
          begin
            tleft_r <= (tleft_r == '0) ? '0 : tleft_r - TW'(1);
            if (tleft_r <= TW'(1) || (seg_end_r >= freq_out ? seg_end_r - freq_out
                : freq_out - seg_end_r) <= step_r)
            begin
              freq_out <= seg_end_r;
              if (is_log && piece_r > 5'h01)
              begin
                piece_r   <= piece_r - 5'h01;
                seg_end_r <= (piece_r == 5'h02) ? b_r
                             : seg_end_r + ((b_r - a_r) / FW'(cont_r ? `FSS_LOG_CONT
                             : `FSS_LOG_SINGLE));
                tleft_r   <= time_r;
              end
              else if (is_disc)
                st_r <= fss_pkg::FSS_SEEK;
              else if (cont_r && !is_log)
              begin
                up_r      <= ~up_r;
                seg_end_r <= up_r ? a_r : b_r;
                tleft_r   <= time_r;
              end
              else if (cont_r)
              begin
                freq_out  <= a_r;
                piece_r   <= `FSS_LOG_CONT;
                seg_end_r <= a_r + ((b_r - a_r) >> 1);
                tleft_r   <= time_r;
              end
              else
              begin
                st_r       <= fss_pkg::FSS_HELD;
                single_act <= 1'b0;
              end
            end
            else
              freq_out <= (seg_end_r >= freq_out) ? freq_out + step_r : freq_out - step_r;
          end
        end
        default:
          st_r <= fss_pkg::FSS_IDLE;
      endcase
    end

endmodule

// ---- tb/fss_seq_chk_sva.sv ----
// Port-level assertion checker for the sweep sequencer
`timescale 1ns/1ps
module fss_seq_chk #(
  parameter int FW = 32,
  parameter int TW = 32
) (
  // Clock, reset, mode
  input wire logic          clk, rst_b, enh_on,
  input wire logic [1:0]    mode_sel,
  // Parameter entry and strobes
  input wire logic          par_load, cmd_rst_start, cmd_start, cmd_bw_dbl, cmd_bw_half,
  input wire logic          cmd_abort, cmd_other_par, cmd_store, cmd_recall, cmd_clear,
  input wire logic [FW-1:0] start_in,
  // Watched outputs
  input wire logic [FW-1:0] freq_out, start_r, stop_r,
  input wire logic          single_act, cont_act, marker_out, xramp_rst
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // No strobe that could move the sweep on its own
  wire logic quiet = !(par_load | cmd_rst_start | cmd_start | cmd_bw_dbl | cmd_bw_half
                     | cmd_abort | cmd_recall | cmd_clear | cmd_store);
  load_par_a: assert property (par_load |=> start_r == $past(start_in))
    else $error("start not loaded");
  reset_start_a: assert property (cmd_rst_start && !single_act && !cont_act
    && mode_sel == 2'h0 && !par_load |=> freq_out == start_r) else $error("not at start");
  ramp_pulse_a: assert property (xramp_rst |=> !xramp_rst)
    else $error("ramp reset too long");
  one_flag_a: assert property (!(single_act && cont_act))
    else $error("both sweep flags");
  mkr_up_a: assert property (cont_act && marker_out && mode_sel == 2'h0
    && start_r < stop_r |-> freq_out >= $past(freq_out)) else $error("marker on down");
  cont_stop_a: assert property (cont_act && (cmd_start || cmd_rst_start || cmd_abort)
    |=> !cont_act) else $error("sweep kept running");
  enh_keep_a: assert property (cont_act && enh_on && cmd_other_par && quiet
    |=> cont_act) else $error("sweep stopped");
  hold_freq_a: assert property ($fell(cont_act) && quiet |=> $stable(freq_out))
    else $error("stopped freq moved");
  disc_bw_a: assert property ((cmd_bw_dbl || cmd_bw_half) && mode_sel == 2'h2
    && !par_load && !cmd_recall |=> $stable(start_r) && $stable(stop_r)) else $error("span moved");
  end_stop_a: assert property ($fell(single_act) && mode_sel == 2'h0 && $past(quiet)
    |-> freq_out == stop_r) else $error("not at stop");
endmodule
bind fss_sweep_seq fss_seq_chk #(.FW(FW), .TW(TW)) u_chk (.clk(clk), .rst_b(rst_b),
  .enh_on(enh_on), .mode_sel(mode_sel), .par_load(par_load), .cmd_rst_start(cmd_rst_start),
  .cmd_start(cmd_start), .cmd_bw_dbl(cmd_bw_dbl), .cmd_bw_half(cmd_bw_half),
  .cmd_abort(cmd_abort), .cmd_other_par(cmd_other_par), .cmd_store(cmd_store),
  .cmd_recall(cmd_recall), .cmd_clear(cmd_clear), .start_in(start_in), .freq_out(freq_out),
  .start_r(start_r), .stop_r(stop_r), .single_act(single_act), .cont_act(cont_act),
  .marker_out(marker_out), .xramp_rst(xramp_rst));

// ---- tb/fss_panel_mdl.sv ----
// Command source model: key strobes and parameter entry
`timescale 1ns/1ps
module fss_panel_mdl (
  input  wire logic  clk,
  output logic [8:0]  cmd,
  output logic        par_load,
  output logic [31:0] s, p, m, t
);
  initial {cmd, par_load, s, p, m, t} = '0;
  // One key gives one strobe with a gap, never back to back
  task automatic key(input int k);
    @(posedge clk); #1 cmd[k] = 1'b1;
    @(posedge clk); #1 cmd = '0;
  endtask
  // Log entries are widened to at least a rising decade
  task automatic enter(input logic [31:0] a, b, c, d, input logic lg);
    @(posedge clk); #1 s = a;
    p = (lg && b < 10 * a) ? 10 * a : b;
    m = c;
    t = d;
    par_load = 1'b1;
    @(posedge clk); #1 par_load = 1'b0;
  endtask
endmodule

// ---- tb/fss_sweep_seq_tb.sv ----
// Self-checking bench for the frequency sweep sequencer
`timescale 1ns/1ps
`include "fss_regs.svh"
module fss_sweep_seq_tb;
  logic clk = 1'b0, rst_b = 1'b0, enh_on = 1'b0, sa_q = 1'b0, er_q = 1'b0;
  logic [1:0] mode_sel = 2'h0;
  logic [6:0] seg_idx = 7'h00;
  logic [31:0] f_min = 32'h000003E8, f_max = 32'h05F5E100, a, b;
  logic [31:0] s_in, p_in, m_in, t_in, freq_out, start_r, stop_r, mkr_r, time_r;
  logic [8:0] cmd;
  logic par_load, single_act, cont_act, marker_out, xramp_rst, err_r;
  logic [9:0] err_code;
  logic [31:0] exp_q[$];
  int fails = 0, check_count = 0;
  fss_panel_mdl PM (.clk(clk), .cmd(cmd), .par_load(par_load), .s(s_in), .p(p_in), .m(m_in),
    .t(t_in));
  fss_sweep_seq #(.TICK_CYC(4)) DUT (.clk(clk), .rst_b(rst_b), .mode_sel(mode_sel),
    .enh_on(enh_on), .start_in(s_in), .stop_in(p_in), .mkr_in(m_in), .time_in(t_in),
    .par_load(par_load), .f_min(f_min), .f_max(f_max), .cmd_rst_start(cmd[0]),
    .cmd_start(cmd[1]), .cmd_bw_dbl(cmd[2]), .cmd_bw_half(cmd[3]), .cmd_abort(cmd[4]),
    .cmd_other_par(cmd[5]), .cmd_store(cmd[6]), .cmd_recall(cmd[7]), .cmd_clear(cmd[8]),
    .seg_idx(seg_idx), .freq_out(freq_out), .start_r(start_r), .stop_r(stop_r),
    .mkr_r(mkr_r), .time_r(time_r), .single_act(single_act), .cont_act(cont_act),
    .marker_out(marker_out), .xramp_rst(xramp_rst), .err_r(err_r), .err_code(err_code));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin fails++; $display("BAD %0t got %0h exp %0h", $time, got, exp); end
  endtask
  task automatic chk_b(input logic got, exp);
    check_count++;
    if (got !== exp) begin fails++; $display("BAD %0t flag %b", $time, got); end
  endtask
  // Driver notes the end frequency; the watcher below compares it
  task automatic run_single(input logic [31:0] fe);
    exp_q.push_back(fe);
    PM.key(0);
    PM.key(0);
    repeat (3) @(posedge clk);
    chk_b(single_act, 1'b1);
    for (int n = 0; n < 5000 && single_act; n++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  // Results are judged away from the edge, one note per event
  always @(negedge clk) begin
    if (sa_q && !single_act && exp_q.size() > 0) chk(freq_out, exp_q.pop_front());
    if (!er_q && err_r) chk({22'h0, err_code}, exp_q.pop_front());
    sa_q <= single_act;
    er_q <= err_r;
  end
  task automatic give_verdict;
    $display("%0d checks, %0d fails", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin #3000000; fails++; give_verdict; end
  initial begin
    void'($urandom(32'h7F0430FF));
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    chk(start_r, `FSS_FREQ_RST);
    chk(stop_r, `FSS_STOP_RST);
    // Spans kept at whole steps per tick
    for (int i = 0; i < 2; i++) begin
      a = 32'h000F4240 + ($urandom % 1000) * 10;
      b = a + 32'h00002710;
      if (i == 1) {a, b} = {b, a};
      PM.enter(a, b, a, 32'h5, 1'b0);
      PM.key(0);
      chk_b(xramp_rst, 1'b1);
      @(posedge clk); #1 chk(freq_out, a);
      chk_b(xramp_rst, 1'b0);
      exp_q.push_back(b);
      PM.key(0);
      for (int n = 0; n < 500 && single_act !== 1'b0; n++) @(posedge clk);
      repeat (3) @(posedge clk);
    end
    $display("single linear done");
    // Random limits that still pass the first doubling and trip the second
    #1 f_min = 32'h00000001 + $urandom % 1000;
    f_max = 32'h00000BB8 + $urandom % 1000;
    PM.enter(32'h3E8, 32'hBB8, 32'h7D0, 32'h5, 1'b0);
    PM.key(3); chk(start_r, 32'h5DC); chk(stop_r, 32'h9C4);
    PM.key(2); chk(start_r, 32'h3E8); chk(stop_r, 32'hBB8);
    exp_q.push_back(32'h001);
    PM.key(2);
    @(posedge clk); #1 mode_sel = 2'h2;
    PM.key(2);
    PM.key(3); chk(start_r, 32'h3E8); chk(stop_r, 32'hBB8);
    $display("span done");
    @(posedge clk); #1 mode_sel = 2'h0; enh_on = 1'b1;
    PM.enter(32'h3E8, 32'h7D0, 32'h5DC, 32'h4, 1'b0);
    foreach (a[k]) if (k < 3) begin
      PM.key(1);
      repeat (40) @(posedge clk);
      chk_b(cont_act, 1'b1);
      #1;
      for (int n = 0; n < 40 && marker_out !== 1'b1; n++) #100;
      chk_b(marker_out, 1'b1);
      PM.key(5); chk_b(cont_act, 1'b1);
      PM.key(k == 0 ? 1 : k == 1 ? 0 : 4); chk_b(cont_act, 1'b0);
      chk_b(freq_out >= 32'h3E8 && freq_out <= 32'h7D0, 1'b1);
    end
    $display("continuous done");
    @(posedge clk); #1 mode_sel = 2'h1;
    PM.enter(32'h64, 32'h3E8, 32'h64, 32'h14, 1'b1);
    run_single(32'h3E8);
    $display("log done");
    #1 mode_sel = 2'h2; seg_idx = 7'h05;
    PM.key(8);
    PM.enter(32'h7D0, 32'hFA0, 32'h7D0, 32'h3, 1'b0);
    PM.key(6);
    @(posedge clk); #1 seg_idx = 7'h00;
    PM.enter(32'h3E8, 32'h5DC, 32'h3E8, 32'h3, 1'b0);
    PM.key(6);
    @(posedge clk); #1 seg_idx = 7'h07; exp_q.push_back(32'h25D);
    PM.key(7);
    @(posedge clk); #1 seg_idx = 7'h05;
    PM.key(7); chk(start_r, 32'h7D0); chk(stop_r, 32'hFA0);
    chk(mkr_r, 32'h7D0); chk(time_r, 32'h3);
    run_single(32'hFA0);
    PM.key(0); PM.key(0); repeat (6) @(posedge clk);
    PM.key(0); chk_b(single_act, 1'b0);
    PM.key(0); @(posedge clk); #1 chk(freq_out, 32'h3E8);
    PM.key(1); repeat (400) @(posedge clk); chk_b(cont_act, 1'b1);
    PM.key(1); chk_b(cont_act, 1'b0);
    PM.enter(32'h3E8, 32'h5DC, 32'h3E8, 32'h3, 1'b0);
    PM.key(8);
    @(posedge clk); #1 seg_idx = 7'h00; exp_q.push_back(32'h25D);
    PM.key(7);
    repeat (3) @(posedge clk);
    $display("discrete done");
    give_verdict;
  end
endmodule
